// File: rtl/io_cond_map.svh
`ifndef IO_COND_MAP_SVH
`define IO_COND_MAP_SVH

// Clock and millisecond tick
`define CLK_PERIOD_NS 50
`define MS_NS 1000000
`define MS_CYCLES (`MS_NS / `CLK_PERIOD_NS)

// Confirmation time in ms, and UP/DOWN rate in mHz per ms
`define CONFIRM_MAX_MS 15'h7530
`define CONFIRM_RST_MS 15'h0005
`define RATE_MIN 10'h001
`define RATE_MAX 10'h3e8
`define RATE_RST 10'h001

// Register byte offsets
`define OFF_POLARITY 8'h00
`define OFF_CONFIRM 8'h04
`define OFF_CTRL 8'h08
`define OFF_RATE 8'h0c
`define OFF_IN_FUNC_A 8'h10
`define OFF_IN_FUNC_B 8'h14
`define OFF_OUT_FUNC 8'h18
`define OFF_THRESH 8'h1c
`define OFF_COUNT_SP1 8'h20
`define OFF_COUNT_SP2 8'h24
`define OFF_FREQ_CMD 8'h28
`define OFF_STATUS 8'h2c
`define OFF_ANGLE_LO 8'h30
`define OFF_ANGLE_HI 8'h34

// Control register fields
`define CTRL_UDMODE_LSB 0
`define CTRL_FWDREV_BIT 2
`define CTRL_NOSAVE_BIT 7
`define CTRL_WIRE_LSB 8

// Reset values
`define POLARITY_RST 16'h0000
`define OUT_FUNC_RST 24'h00000b
`define IN_FUNC_RST 56'h000000000000f1f0

// UP/DOWN modes
`define UD_ACCEL 2'h0
`define UD_CONST 2'h1
`define UD_PULSE 2'h2
`define UD_TERM 2'h3

// Input function codes
`define FN_FWD 8'hf0
`define FN_REV 8'hf1
`define FN_UP 8'h13
`define FN_DOWN 8'h14
`define FN_OOB 8'h52
`define FN_MSEL0 8'h53
`define FN_MSEL1 8'h54

// Output function codes
`define OF_RUN 8'h01
`define OF_UV 8'h0a
`define OF_FAULT 8'h0b
`define OF_SLIP 8'h10
`define OF_CNT1 8'h11
`define OF_CNT2 8'h12
`define OF_BB 8'h13
`define OF_FWD 8'h19
`define OF_REV 8'h1a
`define OF_FGE 8'h1d
`define OF_FLT 8'h1e
`define OF_ZERO 8'h21
`define OF_ZSTOP 8'h22

`endif

// File: rtl/io_cond_pkg.sv
package io_cond_pkg;

	// Conditions that an output terminal may report
	typedef struct packed {
		logic running;
		logic fault;
		logic uv;
		logic slip;
		logic cnt1;
		logic cnt2;
		logic bb;
		logic forward_run_input;
		logic reverse_run_input;
		logic fge;
		logic flt;
		logic zero;
		logic zstop;
	} out_cond_t;

	// Function codes of the three outputs
	typedef struct packed {
		logic [7:0] tb;
		logic [7:0] ta;
		logic [7:0] relay;
	} out_sel_t;

endpackage

// File: rtl/drive_terminal_io_conditioning.sv
`timescale 1ns/10ps
`include "io_cond_map.svh"

// Operation
// - Confirmation time 0..30 s, default 5 ms
// - Accept level only after stable confirmation time
// - Polarity bits 0..6 per input, 1 inverts
// - Inversion of inputs 3..7 independent of sink or source wiring
// - Inputs 1/2 default run; wire mode blocks inversion
// - Polarity writes force terminal states by communication
// - Config bit hands run inputs to polarity bits
// - Codes 83/84 pick one of four motors
// - Code 82 publishes balance angle in two registers
// - UP/DOWN mode codes 0..3, default 0
// - Constant rate 0.001..1.000 Hz/ms, default 0.001
// - Stepping only through inputs coded 19 and 20
// - No-save bit clears command at stop
// - Constant mode steps at programmed rate per ms
// - Three output selects, relay default 11, others 0
// - Output code 19 follows external base block
// - Code 17 first setpoint, code 18 second wraps
// - Codes 29/30 compare frequency with threshold
// - Codes 33/34 zero actual frequency, 34 stopped
module drive_terminal_io_conditioning
	import io_cond_pkg::*;
#(
	parameter int MS_CYCLES = `MS_CYCLES,
	parameter logic [19:0] FREQ_MAX = 20'h0ea60
) (
	input wire logic clock_i,
	input wire logic rst_n_i,
	input wire logic [6:0] input_terminals_i,
	input wire logic running_i,
	input wire logic fault_i,
	input wire logic undervoltage_warn_i,
	input wire logic slip_fault_i,
	input wire logic base_block_i,
	input wire logic counter_pulse_i,
	input wire logic [19:0] out_freq_i,
	input wire logic [9:0] accel_step_i,
	input wire logic [9:0] decel_step_i,
	input wire logic [31:0] balance_angle_i,
	output logic forward_run_o,
	output logic reverse_run_o,
	output logic [1:0] motor_select_o,
	output logic out_of_balance_detect_o,
	output logic [19:0] freq_cmd_o,
	output logic relay_output_o,
	output logic transistor_output_a_o,
	output logic transistor_output_b_o,
	input wire logic awvalid_i,
	output logic awready_o,
	input wire logic [7:0] awaddr_i,
	input wire logic wvalid_i,
	output logic wready_o,
	input wire logic [31:0] wdata_i,
	input wire logic [3:0] wstrb_i,
	output logic bvalid_o,
	input wire logic bready_i,
	output logic [1:0] bresp_o,
	input wire logic arvalid_i,
	output logic arready_o,
	input wire logic [7:0] araddr_i,
	output logic rvalid_o,
	input wire logic rready_i,
	output logic [31:0] rdata_o,
	output logic [1:0] rresp_o
);

	// Byte-lane merge of a bus write into a stored word
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data,
			input logic [3:0] strb);
		logic [31:0] res;
		res = old;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) begin
				res[8*b +: 8] = data[8*b +: 8];
			end
		end
		return res;
	endfunction

	// True when any accepted input carries the given function code
	function automatic logic func_on(input logic [6:0] acc, input logic [6:0][7:0] codes,
			input logic [7:0] code);
		logic hit;
		hit = 1'b0;
		for (int i = 0; i < 7; i++) begin
			hit = hit | (acc[i] && codes[i] == code);
		end
		return hit;
	endfunction

	// Output terminal evaluation
	function automatic logic out_eval(input logic [7:0] code, input out_cond_t c);
		logic v;
		unique case (code)
			`OF_RUN: v = c.running;
			`OF_UV: v = c.uv;
			`OF_FAULT: v = c.fault;
			`OF_SLIP: v = c.slip;
			`OF_CNT1: v = c.cnt1;
			`OF_CNT2: v = c.cnt2;
			`OF_BB: v = c.bb;
			`OF_FWD: v = c.forward_run_input;
			`OF_REV: v = c.reverse_run_input;
			`OF_FGE: v = c.fge;
			`OF_FLT: v = c.flt;
			`OF_ZERO: v = c.zero;
			`OF_ZSTOP: v = c.zstop;
			default: v = 1'b0;
		endcase
		return v;
	endfunction

	logic [15:0] polarity_reg;
	logic [14:0] confirm_ms_reg;
	logic [1:0] ud_mode_reg;
	logic fwd_rev_by_pol_reg;
	logic no_save_reg;
	logic [1:0] wire_mode_reg;
	logic [9:0] rate_reg;
	logic [6:0][7:0] in_func_reg;
	out_sel_t out_sel_reg;
	logic [19:0] thresh_reg;
	logic [15:0] count_sp1_reg;
	logic [15:0] count_sp2_reg;
	logic [19:0] freq_cmd_reg;
	logic [15:0] count_reg;
	logic reach2_reg;
	logic [31:0] angle_reg;
	logic [6:0] sync1_reg;
	logic [6:0] sync2_reg;
	logic [6:0] accepted_reg;
	logic [14:0] stable_cnt_reg [7];
	logic [14:0] ms_cnt_reg;
	logic ms_tick;
	logic [6:0] logical;
	logic [6:0] ready;
	logic up_prev_reg;
	logic down_prev_reg;
	logic aw_full_reg;
	logic w_full_reg;
	logic [7:0] aw_addr_reg;
	logic [31:0] w_data_reg;
	logic [3:0] w_strb_reg;
	logic wr_en;
	logic wr_hit;
	logic [31:0] wr_word;
	logic [31:0] rd_next;
	logic rd_hit;
	logic up_on;
	logic down_on;
	logic [19:0] step;
	logic step_strobe;
	out_cond_t cond;

	// Millisecond tick; a single clock keeps all timing on one edge
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ms_cnt_reg <= 15'h0000;
		end else if (ms_cnt_reg == 15'(MS_CYCLES - 1)) begin
			ms_cnt_reg <= 15'h0000;
		end else begin
			ms_cnt_reg <= ms_cnt_reg + 15'h0001;
		end
	end
	assign ms_tick = (ms_cnt_reg == 15'(MS_CYCLES - 1));

	// Two-stage synchroniser; nothing but the second stage reads the first
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			sync1_reg <= 7'h00;
			sync2_reg <= 7'h00;
		end else begin
			sync1_reg <= input_terminals_i;
			sync2_reg <= sync1_reg;
		end
	end

	// Polarity: a stored 1 inverts, so software can force a terminal on
	always_comb begin
		logical = sync2_reg ^ polarity_reg[6:0];
		if (wire_mode_reg != 2'h0) begin
			logical[1:0] = sync2_reg[1:0];
		end
	end

	// A differing level must outlast the confirmation time
	always_comb begin
		for (int i = 0; i < 7; i++) begin
			ready[i] = (logical[i] != accepted_reg[i]) &&
				(stable_cnt_reg[i] >= confirm_ms_reg);
		end
	end

	// Confirmation filter; a bounce restarts the count from zero
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			accepted_reg <= 7'h00;
			for (int i = 0; i < 7; i++) begin
				stable_cnt_reg[i] <= 15'h0000;
			end
		end else begin
			for (int i = 0; i < 7; i++) begin
				if (logical[i] == accepted_reg[i]) begin
					stable_cnt_reg[i] <= 15'h0000;
				end else if (ready[i]) begin
					accepted_reg[i] <= logical[i];
					stable_cnt_reg[i] <= 15'h0000;
				end else if (ms_tick) begin
					stable_cnt_reg[i] <= stable_cnt_reg[i] + 15'h0001;
				end
			end
		end
	end

	// Decoded input functions
	assign up_on = func_on(accepted_reg, in_func_reg, `FN_UP);
	assign down_on = func_on(accepted_reg, in_func_reg, `FN_DOWN);

	// Run, motor set and balance outputs, all registered
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			forward_run_o <= 1'b0;
			reverse_run_o <= 1'b0;
			motor_select_o <= 2'h0;
			out_of_balance_detect_o <= 1'b0;
		end else begin
			if (fwd_rev_by_pol_reg) begin
				forward_run_o <= polarity_reg[0];
				reverse_run_o <= polarity_reg[1];
			end else begin
				forward_run_o <= func_on(accepted_reg, in_func_reg, `FN_FWD);
				reverse_run_o <= func_on(accepted_reg, in_func_reg, `FN_REV);
			end
			motor_select_o <= {func_on(accepted_reg, in_func_reg, `FN_MSEL1),
				func_on(accepted_reg, in_func_reg, `FN_MSEL0)};
			out_of_balance_detect_o <= func_on(accepted_reg, in_func_reg, `FN_OOB);
		end
	end

	// Angle is frozen once the balance input drops
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			angle_reg <= 32'h00000000;
		end else if (func_on(accepted_reg, in_func_reg, `FN_OOB)) begin
			angle_reg <= balance_angle_i;
		end
	end

	// Step size and moment per UP/DOWN mode
	always_comb begin
		step = {10'h000, rate_reg};
		step_strobe = 1'b0;
		unique case (ud_mode_reg)
			`UD_ACCEL: begin
				step = {10'h000, up_on ? accel_step_i : decel_step_i};
				step_strobe = ms_tick;
			end
			`UD_CONST: step_strobe = ms_tick;
			`UD_PULSE: step_strobe = (up_on && !up_prev_reg) || (down_on && !down_prev_reg);
			`UD_TERM: step_strobe = ms_tick;
		endcase
	end

	// Edge memory for pulse mode
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			up_prev_reg <= 1'b0;
			down_prev_reg <= 1'b0;
		end else begin
			up_prev_reg <= up_on;
			down_prev_reg <= down_on;
		end
	end

	// Frequency command; both keys held cancel each other
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			freq_cmd_reg <= 20'h00000;
		end else if (no_save_reg && !running_i) begin
			freq_cmd_reg <= 20'h00000;
		end else if (step_strobe && up_on && !down_on) begin
			if ({1'b0, freq_cmd_reg} + {1'b0, step} >= {1'b0, FREQ_MAX}) begin
				freq_cmd_reg <= FREQ_MAX;
			end else begin
				freq_cmd_reg <= freq_cmd_reg + step;
			end
		end else if (step_strobe && down_on && !up_on) begin
			freq_cmd_reg <= (freq_cmd_reg > step) ? freq_cmd_reg - step : 20'h00000;
		end else if (wr_en && aw_addr_reg == `OFF_FREQ_CMD) begin
			freq_cmd_reg <= wr_word[19:0];
		end
	end
	assign freq_cmd_o = freq_cmd_reg;

	// External counter; the second setpoint wraps the count
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			count_reg <= 16'h0000;
			reach2_reg <= 1'b0;
		end else if (counter_pulse_i) begin
			if (count_reg + 16'h0001 == count_sp2_reg) begin
				count_reg <= 16'h0000;
				reach2_reg <= 1'b1;
			end else begin
				count_reg <= count_reg + 16'h0001;
				reach2_reg <= 1'b0;
			end
		end
	end

	// Condition vector for the output selects
	always_comb begin
		cond.running = running_i;
		cond.fault = fault_i;
		cond.uv = undervoltage_warn_i;
		cond.slip = slip_fault_i;
		cond.cnt1 = (count_reg == count_sp1_reg) && (count_sp1_reg <= count_sp2_reg);
		cond.cnt2 = reach2_reg;
		cond.bb = base_block_i;
		cond.forward_run_input = forward_run_o;
		cond.reverse_run_input = reverse_run_o;
		cond.fge = out_freq_i >= thresh_reg;
		cond.flt = out_freq_i < thresh_reg;
		cond.zero = running_i && out_freq_i == 20'h00000;
		cond.zstop = !running_i || out_freq_i == 20'h00000;
	end

	// Output terminals
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			relay_output_o <= 1'b0;
			transistor_output_a_o <= 1'b0;
			transistor_output_b_o <= 1'b0;
		end else begin
			relay_output_o <= out_eval(out_sel_reg.relay, cond);
			transistor_output_a_o <= out_eval(out_sel_reg.ta, cond);
			transistor_output_b_o <= out_eval(out_sel_reg.tb, cond);
		end
	end

	// Write channels are held separately so either may come first
	assign awready_o = !aw_full_reg;
	assign wready_o = !w_full_reg;
	assign wr_en = aw_full_reg && w_full_reg && !bvalid_o;
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			aw_full_reg <= 1'b0;
			w_full_reg <= 1'b0;
			aw_addr_reg <= 8'h00;
			w_data_reg <= 32'h00000000;
			w_strb_reg <= 4'h0;
			bvalid_o <= 1'b0;
			bresp_o <= 2'h0;
		end else begin
			if (awvalid_i && awready_o) begin
				aw_full_reg <= 1'b1;
				aw_addr_reg <= awaddr_i;
			end else if (wr_en) begin
				aw_full_reg <= 1'b0;
			end
			if (wvalid_i && wready_o) begin
				w_full_reg <= 1'b1;
				w_data_reg <= wdata_i;
				w_strb_reg <= wstrb_i;
			end else if (wr_en) begin
				w_full_reg <= 1'b0;
			end
			if (wr_en) begin
				bvalid_o <= 1'b1;
				bresp_o <= wr_hit ? 2'h0 : 2'h2;
			end else if (bready_i) begin
				bvalid_o <= 1'b0;
			end
		end
	end

	// Write data merged with the addressed register's current value
	always_comb begin
		wr_hit = 1'b1;
		wr_word = merge(rd_next, w_data_reg, w_strb_reg);
		unique case (aw_addr_reg)
			`OFF_POLARITY, `OFF_CONFIRM, `OFF_CTRL, `OFF_RATE, `OFF_IN_FUNC_A,
			`OFF_IN_FUNC_B, `OFF_OUT_FUNC, `OFF_THRESH, `OFF_COUNT_SP1,
			`OFF_COUNT_SP2, `OFF_FREQ_CMD: wr_hit = 1'b1;
			default: wr_hit = 1'b0;
		endcase
	end

	// Configuration registers; out-of-range values are clamped
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			polarity_reg <= `POLARITY_RST;
			confirm_ms_reg <= `CONFIRM_RST_MS;
			ud_mode_reg <= `UD_ACCEL;
			fwd_rev_by_pol_reg <= 1'b0;
			no_save_reg <= 1'b0;
			wire_mode_reg <= 2'h0;
			rate_reg <= `RATE_RST;
			in_func_reg <= `IN_FUNC_RST;
			out_sel_reg <= `OUT_FUNC_RST;
			thresh_reg <= 20'h00000;
			count_sp1_reg <= 16'h0000;
			count_sp2_reg <= 16'h0000;
		end else if (wr_en) begin
			unique case (aw_addr_reg)
				`OFF_POLARITY: polarity_reg <= wr_word[15:0];
				`OFF_CONFIRM: confirm_ms_reg <= (wr_word[31:0] > 32'(`CONFIRM_MAX_MS)) ?
					`CONFIRM_MAX_MS : wr_word[14:0];
				`OFF_CTRL: begin
					ud_mode_reg <= wr_word[`CTRL_UDMODE_LSB +: 2];
					fwd_rev_by_pol_reg <= wr_word[`CTRL_FWDREV_BIT];
					no_save_reg <= wr_word[`CTRL_NOSAVE_BIT];
					wire_mode_reg <= wr_word[`CTRL_WIRE_LSB +: 2];
				end
				`OFF_RATE: begin
					if (wr_word > 32'(`RATE_MAX)) begin
						rate_reg <= `RATE_MAX;
					end else if (wr_word < 32'(`RATE_MIN)) begin
						rate_reg <= `RATE_MIN;
					end else begin
						rate_reg <= wr_word[9:0];
					end
				end
				`OFF_IN_FUNC_A: in_func_reg[3:0] <= wr_word;
				`OFF_IN_FUNC_B: in_func_reg[6:4] <= wr_word[23:0];
				`OFF_OUT_FUNC: out_sel_reg <= wr_word[23:0];
				`OFF_THRESH: thresh_reg <= wr_word[19:0];
				`OFF_COUNT_SP1: count_sp1_reg <= wr_word[15:0];
				`OFF_COUNT_SP2: count_sp2_reg <= wr_word[15:0];
				default: ;
			endcase
		end
	end

	// Register read map; the write path reuses it for byte merging
	always_comb begin
		rd_next = 32'h00000000;
		rd_hit = 1'b1;
		unique case (wr_en ? aw_addr_reg : araddr_i)
			`OFF_POLARITY: rd_next = {16'h0000, polarity_reg};
			`OFF_CONFIRM: rd_next = {17'h00000, confirm_ms_reg};
			`OFF_CTRL: rd_next = {22'h000000, wire_mode_reg, no_save_reg, 4'h0,
				fwd_rev_by_pol_reg, ud_mode_reg};
			`OFF_RATE: rd_next = {22'h000000, rate_reg};
			`OFF_IN_FUNC_A: rd_next = in_func_reg[3:0];
			`OFF_IN_FUNC_B: rd_next = {8'h00, in_func_reg[6:4]};
			`OFF_OUT_FUNC: rd_next = {8'h00, out_sel_reg};
			`OFF_THRESH: rd_next = {12'h000, thresh_reg};
			`OFF_COUNT_SP1: rd_next = {16'h0000, count_sp1_reg};
			`OFF_COUNT_SP2: rd_next = {16'h0000, count_sp2_reg};
			`OFF_FREQ_CMD: rd_next = {12'h000, freq_cmd_reg};
			`OFF_STATUS: rd_next = {count_reg, 1'b0, transistor_output_b_o,
				transistor_output_a_o, relay_output_o, motor_select_o, 3'h0, accepted_reg};
			`OFF_ANGLE_LO: rd_next = {16'h0000, angle_reg[15:0]};
			`OFF_ANGLE_HI: rd_next = {16'h0000, angle_reg[31:16]};
			default: rd_hit = 1'b0;
		endcase
	end

	// Read channel, one outstanding read; held off while a write borrows the read mux
	assign arready_o = !rvalid_o && !wr_en;
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rvalid_o <= 1'b0;
			rdata_o <= 32'h00000000;
			rresp_o <= 2'h0;
		end else if (arvalid_i && arready_o) begin
			rvalid_o <= 1'b1;
			rdata_o <= rd_next;
			rresp_o <= rd_hit ? 2'h0 : 2'h2;
		end else if (rready_i) begin
			rvalid_o <= 1'b0;
		end
	end

	a_confirm_range:
	assert property (@(posedge clock_i) disable iff (!rst_n_i)
		confirm_ms_reg <= `CONFIRM_MAX_MS) else $error("confirm time above limit");

	a_accept_only_ready:
	assert property (@(posedge clock_i) disable iff (!rst_n_i)
		!$stable(accepted_reg) |-> $past(ready) != 7'h00) else $error("input accepted early");

	a_sync_two_stage:
	assert property (@(posedge clock_i) disable iff (!rst_n_i)
		$past(rst_n_i, 2) |-> sync2_reg == $past(input_terminals_i, 2))
		else $error("synchroniser depth wrong");

	a_fwd_from_pol:
	assert property (@(posedge clock_i) disable iff (!rst_n_i)
		fwd_rev_by_pol_reg ##1 $stable(polarity_reg) |->
		forward_run_o == polarity_reg[0] && reverse_run_o == polarity_reg[1])
		else $error("run inputs not taken from polarity");

	a_motor_pair:
	assert property (@(posedge clock_i) disable iff (!rst_n_i)
		motor_select_o[0] == $past(func_on(accepted_reg, in_func_reg, `FN_MSEL0)))
		else $error("motor select low bit wrong");

	a_nosave_zero:
	assert property (@(posedge clock_i) disable iff (!rst_n_i)
		no_save_reg && !running_i |=> freq_cmd_reg == 20'h00000)
		else $error("command not cleared at stop");

	a_const_step:
	assert property (@(posedge clock_i) disable iff (!rst_n_i)
		ud_mode_reg == `UD_CONST && ms_tick && up_on && !down_on && running_i &&
		freq_cmd_reg + step < FREQ_MAX |=> freq_cmd_reg == $past(freq_cmd_reg + step))
		else $error("constant rate step wrong");

	a_bb_follow:
	assert property (@(posedge clock_i) disable iff (!rst_n_i)
		out_sel_reg.relay == `OF_BB |=> relay_output_o == $past(base_block_i))
		else $error("base block output wrong");

	a_unsupported_low:
	assert property (@(posedge clock_i) disable iff (!rst_n_i)
		!(out_sel_reg.ta inside {`OF_RUN, `OF_UV, `OF_FAULT, `OF_SLIP, `OF_CNT1, `OF_CNT2,
		`OF_BB, `OF_FWD, `OF_REV, `OF_FGE, `OF_FLT, `OF_ZERO, `OF_ZSTOP}) |=>
		!transistor_output_a_o)
		else $error("unsupported code drove output");

endmodule

// File: sim/field_contacts.sv
`timescale 1ns/10ps

module field_contacts #(
	parameter int BOUNCE = 3
) (
	input wire logic clock_i,
	input wire logic [6:0] level_i,
	output logic [6:0] terminals_o
);
	logic [6:0] last_reg = 7'h00;
	logic [6:0] chg_reg = 7'h00;
	logic [6:0] out_reg = 7'h00;
	int cnt_reg = 0;

	// Contacts chatter after each change, so the bench never sees clean edges
	always @(posedge clock_i) begin
		if (level_i != last_reg) begin
			chg_reg <= level_i ^ last_reg;
			last_reg <= level_i;
			cnt_reg <= BOUNCE;
		end else if (cnt_reg > 0) begin
			cnt_reg <= cnt_reg - 1;
			out_reg <= out_reg ^ chg_reg;
		end else begin
			out_reg <= last_reg;
		end
	end
	assign terminals_o = out_reg;
endmodule

// File: sim/drive_terminal_io_conditioning_tb.sv
`timescale 1ns/10ps
`include "io_cond_map.svh"

module drive_terminal_io_conditioning_tb;
	logic clock_i, rst_n_i, running, fault, bb, cpulse, uv, slip;
	logic [19:0] ofreq, fcmd;
	logic [9:0] acc, dec;
	logic [31:0] ang, wdata, rdata;
	logic [6:0] level, term;
	logic awvalid, wvalid, bready, arvalid, rready;
	logic awready, wready, bvalid, arready, rvalid;
	logic [7:0] awaddr, araddr;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp, msel, wresp;
	logic forward_run_input, reverse_run_input, out_of_balance_detect, rly, toa, tob;
	int fail_count = 0;
	int n_checks = 0;

	drive_terminal_io_conditioning #(.MS_CYCLES(20)) i_dut (.clock_i(clock_i),
		.rst_n_i(rst_n_i), .input_terminals_i(term), .running_i(running),
		.fault_i(fault), .undervoltage_warn_i(uv), .slip_fault_i(slip),
		.base_block_i(bb), .counter_pulse_i(cpulse), .out_freq_i(ofreq),
		.accel_step_i(acc), .decel_step_i(dec), .balance_angle_i(ang),
		.forward_run_o(forward_run_input), .reverse_run_o(reverse_run_input), .motor_select_o(msel),
		.out_of_balance_detect_o(out_of_balance_detect), .freq_cmd_o(fcmd), .relay_output_o(rly),
		.transistor_output_a_o(toa), .transistor_output_b_o(tob),
		.awvalid_i(awvalid), .awready_o(awready), .awaddr_i(awaddr),
		.wvalid_i(wvalid), .wready_o(wready), .wdata_i(wdata), .wstrb_i(wstrb),
		.bvalid_o(bvalid), .bready_i(bready), .bresp_o(bresp),
		.arvalid_i(arvalid), .arready_o(arready), .araddr_i(araddr),
		.rvalid_o(rvalid), .rready_i(rready), .rdata_o(rdata), .rresp_o(rresp));

	field_contacts i_contacts (.clock_i(clock_i), .level_i(level), .terminals_o(term));

	// Free-running 20 MHz clock
	initial begin
		clock_i = 1'b0;
		forever #25 clock_i = ~clock_i;
	end

	task automatic cyc(input int n);
		repeat (n) @(posedge clock_i);
	endtask

	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			fail_count++;
			$display("mismatch %s exp %h got %h", n, e, g);
		end
	endtask

	// Write: AW and W offered together, each dropped once taken
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic b;
		b = 1'b0;
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!b) begin
			@(posedge clock_i);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
			b = bvalid;
			wresp = bresp;
		end
		bready <= 1'b0;
		@(posedge clock_i);
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		logic b;
		b = 1'b0;
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		while (!b) begin
			@(posedge clock_i);
			if (arready) arvalid <= 1'b0;
			b = rvalid;
			d = rdata;
			r = rresp;
		end
		rready <= 1'b0;
		@(posedge clock_i);
	endtask

	task automatic rchk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
		logic [31:0] d;
		logic [1:0] r;
		rd(a, d, r);
		chk("rdata", e, d);
		chk("rresp", {30'h0, er}, {30'h0, r});
	endtask

	task automatic t_reset;
		logic [7:0] ad [7] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h18, 8'h3c};
		logic [31:0] ex [7] = '{32'h0, 32'h5, 32'h0, 32'h1, 32'hf1f0, 32'hb, 32'h0};
		for (int i = 0; i < 7; i++) rchk(ad[i], ex[i], (i == 6) ? 2'h2 : 2'h0);
		fault <= 1'b1;
		cyc(4);
		chk("relay", 32'h1, {31'h0, rly});
		fault <= 1'b0;
	endtask

	// Run inputs by wiring, by polarity forcing and with wire mode set
	task automatic t_run;
		wr(`OFF_CONFIRM, 32'h0);
		level <= 7'h01;
		cyc(16);
		chk("run", 32'h2, {30'h0, forward_run_input, reverse_run_input});
		wr(`OFF_POLARITY, 32'h1);
		cyc(8);
		chk("run", 32'h0, {30'h0, forward_run_input, reverse_run_input});
		level <= 7'h00;
		wr(`OFF_POLARITY, 32'h9);
		cyc(16);
		chk("run", 32'h2, {30'h0, forward_run_input, reverse_run_input});
		wr(`OFF_CTRL, 32'h100);
		wr(`OFF_POLARITY, 32'h3);
		cyc(8);
		chk("run", 32'h0, {30'h0, forward_run_input, reverse_run_input});
		wr(`OFF_CTRL, 32'h4);
		wr(`OFF_POLARITY, 32'h2);
		cyc(4);
		chk("run", 32'h1, {30'h0, forward_run_input, reverse_run_input});
		wr(`OFF_CTRL, 32'h0);
		wr(`OFF_POLARITY, 32'h0);
	endtask

	task automatic t_motor;
		wr(`OFF_IN_FUNC_A, 32'h5453f1f0);
		for (int i = 0; i < 4; i++) begin
			level <= {3'h0, i[1:0], 2'h0};
			cyc(16);
			chk("motor", i, {30'h0, msel});
		end
		level <= 7'h00;
	endtask

	// Balance input captures the angle, which stays frozen once released
	task automatic t_angle;
		wr(`OFF_IN_FUNC_B, 32'h52);
		chk("bresp", 32'h0, {30'h0, wresp});
		level <= 7'h10;
		cyc(16);
		chk("oob", 32'h1, {31'h0, out_of_balance_detect});
		level <= 7'h00;
		cyc(16);
		chk("oob", 32'h0, {31'h0, out_of_balance_detect});
		ang <= 32'h0;
		rchk(`OFF_ANGLE_LO, 32'h1234, 2'h0);
		rchk(`OFF_ANGLE_HI, 32'h5678, 2'h0);
		wr(`OFF_ANGLE_LO, 32'h0);
		chk("bresp", 32'h2, {30'h0, wresp});
		wr(`OFF_IN_FUNC_B, 32'h0);
	endtask

	// Base block, threshold, zero speed and an unsupported code
	task automatic t_outs;
		wr(`OFF_THRESH, 32'd100);
		wr(`OFF_OUT_FUNC, 32'h1e1d13);
		bb <= 1'b1;
		ofreq <= 20'd100;
		cyc(3);
		chk("outs", 32'h6, {29'h0, rly, toa, tob});
		bb <= 1'b0;
		ofreq <= 20'd99;
		cyc(3);
		chk("outs", 32'h1, {29'h0, rly, toa, tob});
		wr(`OFF_OUT_FUNC, 32'h632122);
		running <= 1'b1;
		ofreq <= 20'd0;
		cyc(3);
		chk("outs", 32'h6, {29'h0, rly, toa, tob});
		running <= 1'b0;
		ofreq <= 20'd5;
		cyc(3);
		chk("outs", 32'h4, {29'h0, rly, toa, tob});
	endtask

	task automatic pulse;
		cpulse <= 1'b1;
		@(posedge clock_i);
		cpulse <= 1'b0;
		@(posedge clock_i);
	endtask

	task automatic t_count;
		wr(`OFF_OUT_FUNC, 32'h001211);
		wr(`OFF_COUNT_SP1, 32'd2);
		wr(`OFF_COUNT_SP2, 32'd3);
		pulse();
		pulse();
		cyc(3);
		chk("count", 32'h2, {30'h0, rly, toa});
		pulse();
		cyc(3);
		chk("count", 32'h1, {30'h0, rly, toa});
	endtask

	task automatic t_updown;
		logic [19:0] f0;
		for (int m = 0; m < 4; m++) begin
			wr(`OFF_CTRL, m);
			rchk(`OFF_CTRL, m, 2'h0);
		end
		wr(`OFF_RATE, 32'd2000);
		rchk(`OFF_RATE, 32'h3e8, 2'h0);
		wr(`OFF_RATE, 32'd5);
		wr(`OFF_CTRL, 32'h1);
		wr(`OFF_IN_FUNC_B, 32'h13);
		running <= 1'b1;
		level <= 7'h10;
		cyc(30);
		f0 = fcmd;
		cyc(200);
		chk("freq", {12'h0, f0} + 32'd50, {12'h0, fcmd});
		wr(`OFF_IN_FUNC_B, 32'h14);
		wr(`OFF_CTRL, 32'h0);
		cyc(30);
		f0 = fcmd;
		cyc(200);
		chk("freq", {12'h0, f0} - 32'd30, {12'h0, fcmd});
		level <= 7'h00;
		wr(`OFF_CTRL, 32'h81);
		running <= 1'b0;
		cyc(5);
		chk("freq", 32'h0, {12'h0, fcmd});
	endtask

	// Short disturbance dropped, steady level accepted
	task automatic t_confirm;
		wr(`OFF_CONFIRM, 32'h2);
		level <= 7'h01;
		cyc(8);
		level <= 7'h00;
		cyc(60);
		chk("run", 32'h0, {31'h0, forward_run_input});
		level <= 7'h01;
		cyc(100);
		chk("run", 32'h1, {31'h0, forward_run_input});
	endtask

	task automatic results;
		if (fail_count == 0 && n_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// Hang guard, well beyond the roughly one thousand cycles the tests need
	initial begin
		repeat (20000) @(posedge clock_i);
		fail_count++;
		results();
	end

	initial begin
		{rst_n_i, running, fault, bb, cpulse, uv, slip} = 7'h00;
		{awvalid, wvalid, bready, arvalid, rready} = 5'h00;
		ofreq = 20'h0;
		acc = 10'h002;
		dec = 10'h003;
		ang = 32'h56781234;
		level = 7'h00;
		awaddr = 8'h00;
		araddr = 8'h00;
		wdata = 32'h0;
		wstrb = 4'hf;
		repeat (6) @(posedge clock_i);
		rst_n_i <= 1'b1;
		@(posedge clock_i);
		t_reset();
		t_run();
		t_motor();
		t_angle();
		t_outs();
		t_count();
		t_updown();
		t_confirm();
		results();
	end
endmodule
